// ===== rtl/dsf_top.sv
// Purpose: Discrete status outputs of a motor drive: arrival, threshold,
//   overload, PID deviation and fault alarm, on two open-collector
//   terminals and one changeover relay
// Assumes: All inputs come from logic on i_mclk; no synchronisers needed
// Notes: Frequency in 0.1 Hz, current and PID values in 0.1 % units
//
// Summary of operation
// - Arrival flag compares output frequency against the target frequency.
// - Arrival flag on within 0.5 Hz below to 1.5 Hz above target.
// - Arrival flag changes reach the terminal 60 ms later.
// - Arrival terminals are active low, transistor conducting when asserted.
// - Threshold flag on at accel level rising, off at decel level falling.
// - Threshold flag also active low, changing 60 ms after crossing.
// - Equal or unequal accel and decel levels are both accepted.
// - Overload warning on above the overload level, off below it.
// - Overload detection works while motoring and while regenerating.
// - Overload level resets to 100 % of rated current.
// - PID error is the absolute difference of setpoint and feedback.
// - PID flag on above the deviation level, off below it.
// - Deviation level resets to 3 %.
// - Alarm asserted while tripped, released when the fault clears.
// - Alarm output follows the fault indication about 300 ms later.
// - Codes 03, 04, 05 select overload, PID flag, alarm on a terminal.
// - Relay rests in normal position powered and healthy, flips otherwise.
// - Relay polarity setting inverts the contact logic.
// - Arrival flag off when output disabled or ramping.
// - Threshold flag stays on at or above its levels during ramps.
`include "dsf_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module dsf_top import dsf_pkg::*; #(
  parameter int CYC_PER_MS = `DSF_MCLK_HZ / `DSF_MS_PER_S,
  parameter int FLAG_DELAY_MS = `DSF_FLAG_DELAY_MS,
  parameter int ALARM_DELAY_MS = `DSF_ALARM_DELAY_MS,
  parameter int VW = 16
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [VW-1:0] i_out_freq,
  input wire logic [VW-1:0] i_target_freq,
  input wire logic [VW-1:0] i_accel_on_freq,
  input wire logic [VW-1:0] i_decel_off_freq,
  input wire logic i_output_enabled,
  input wire logic i_accelerating,
  input wire logic i_decelerating,
  input wire logic [VW-1:0] i_out_current,
  input wire logic [VW-1:0] i_ovl_level,
  input wire logic i_ovl_level_wr,
  input wire logic [VW-1:0] i_pid_setpoint,
  input wire logic [VW-1:0] i_pid_feedback,
  input wire logic [VW-1:0] i_dev_level,
  input wire logic i_dev_level_wr,
  input wire logic i_tripped,
  input wire logic i_power_ok,
  input wire logic i_relay_invert,
  input wire dsf_func_t i_oc_func [2],
  input wire dsf_func_t i_relay_func,
  output logic [1:0] o_oc_oe,
  output logic [1:0] o_oc_n,
  output logic o_relay_contact_a_closed,
  output logic o_relay_contact_b_closed,
  output var dsf_flags_t o_flags
);

  localparam int MW = $clog2(CYC_PER_MS);
  localparam logic [MW-1:0] MS_LAST = MW'(CYC_PER_MS - 1);

  // Terminal function decode, used by both terminals and the relay
  function automatic logic sel_flag(input dsf_func_t code, input dsf_flags_t f);
    logic r;
    r = 1'b0;
    case (code)
      DSF_FN_AT_SPEED: r = f.at_speed_flag;
      DSF_FN_THRESHOLD: r = f.threshold_speed_flag;
      DSF_FN_OVERLOAD: r = f.overcurrent_warning;
      DSF_FN_PID_ERROR: r = f.pid_error_flag;
      DSF_FN_ALARM: r = f.fault_alarm;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic [MW-1:0] ms_cnt_q;
  logic ms_tick;
  logic [VW-1:0] ovl_level_q, dev_level_q;
  logic at_speed_raw_q, thr_raw_q, thr_raw_d, ovl_q, pid_q, trip_q;
  logic at_speed_dly, thr_dly, alarm_dly;
  logic coil_q;

  assign ms_tick = ms_cnt_q == MS_LAST;
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
    end
  end

  // Arrival window, widened by one bit so frequencies near full scale cannot wrap
  wire logic [VW:0] freq_ext = {1'b0, i_out_freq};
  wire logic [VW:0] tgt_ext = {1'b0, i_target_freq};
  wire logic in_lo = freq_ext + (VW+1)'(`DSF_ARRIVE_BELOW) >= tgt_ext;
  wire logic in_hi = freq_ext <= tgt_ext + (VW+1)'(`DSF_ARRIVE_ABOVE);
  wire logic ramping = i_accelerating || i_decelerating;
  wire logic at_speed_d = i_output_enabled && !ramping && in_lo && in_hi;

  // threshold flag, on at accel level, off at decel level
  wire logic acc_cross = i_accelerating && (i_out_freq >= i_accel_on_freq);
  wire logic dec_cross = i_decelerating && (i_out_freq < i_decel_off_freq);
  always_comb begin
    thr_raw_d = thr_raw_q;
    if (!i_output_enabled) begin
      thr_raw_d = 1'b0;
    end else if (acc_cross) begin
      thr_raw_d = 1'b1;
    end else if (dec_cross) begin
      thr_raw_d = 1'b0;
    end
  end

  wire logic [VW-1:0] pid_err = (i_pid_setpoint >= i_pid_feedback) ?
    i_pid_setpoint - i_pid_feedback : i_pid_feedback - i_pid_setpoint;

  // compare independent of motoring or regenerating; equal holds
  wire logic ovl_d = (i_out_current > ovl_level_q) ? 1'b1 :
    (i_out_current < ovl_level_q) ? 1'b0 : ovl_q;
  wire logic pid_d = (pid_err > dev_level_q) ? 1'b1 :
    (pid_err < dev_level_q) ? 1'b0 : pid_q;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      ovl_level_q <= `DSF_OVL_DEFAULT;
      dev_level_q <= `DSF_DEV_DEFAULT;
    end else begin
      if (i_ovl_level_wr) ovl_level_q <= i_ovl_level;
      if (i_dev_level_wr) dev_level_q <= i_dev_level;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      at_speed_raw_q <= 1'b0;
      thr_raw_q <= 1'b0;
      ovl_q <= 1'b0;
      pid_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      at_speed_raw_q <= at_speed_d;
      thr_raw_q <= thr_raw_d;
      ovl_q <= ovl_d;
      pid_q <= pid_d;
      trip_q <= i_tripped;
    end
  end

  dsf_delay #(.DELAY_MS(FLAG_DELAY_MS)) u_dly_at_speed (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ms_tick(ms_tick),
    .i_in(at_speed_raw_q),
    .o_out(at_speed_dly)
  );
  dsf_delay #(.DELAY_MS(FLAG_DELAY_MS)) u_dly_threshold (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ms_tick(ms_tick),
    .i_in(thr_raw_q),
    .o_out(thr_dly)
  );
  dsf_delay #(.DELAY_MS(ALARM_DELAY_MS)) u_dly_alarm (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_ms_tick(ms_tick),
    .i_in(trip_q),
    .o_out(alarm_dly)
  );

  // Flag bundle, all bits from flip-flops
  wire dsf_flags_t flags = '{
    at_speed_flag: at_speed_dly,
    threshold_speed_flag: thr_dly,
    overcurrent_warning: ovl_q,
    pid_error_flag: pid_q,
    fault_alarm: alarm_dly
  };
  assign o_flags = flags;

  generate
    for (genvar t = 0; t < 2; t++) begin : g_oc
      always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
          o_oc_oe[t] <= 1'b0;
          o_oc_n[t] <= 1'b1;
        end else begin
          o_oc_oe[t] <= sel_flag(i_oc_func[t], flags);
          o_oc_n[t] <= !sel_flag(i_oc_func[t], flags);
        end
      end
    end
  endgenerate

  // relay coil, energised in normal state with polarity not inverted, dropped when unpowered
  wire logic relay_sel = sel_flag(i_relay_func, flags);
  wire logic coil_d = i_power_ok && (i_relay_invert ? relay_sel : !relay_sel);
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      coil_q <= 1'b0;
    end else begin
      coil_q <= coil_d;
    end
  end
  // Contact a closes with the coil, contact b rests closed
  assign o_relay_contact_a_closed = coil_q;
  assign o_relay_contact_b_closed = !coil_q;

  // Checks on the flag logic
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence s_accel_cross;
    i_output_enabled && i_accelerating && (i_out_freq >= i_accel_on_freq);
  endsequence

  sequence s_decel_cross;
    i_output_enabled && !(i_accelerating && (i_out_freq >= i_accel_on_freq)) &&
      i_decelerating && (i_out_freq < i_decel_off_freq);
  endsequence

  sequence s_cruise;
    i_output_enabled && !ramping && (i_out_freq == i_target_freq);
  endsequence

  a_arrive_window_on: assert property (
    s_cruise |=> at_speed_raw_q)
    else $error("Arrival flag not set at target frequency");

  a_arrive_ramp_off: assert property (
    (ramping || !i_output_enabled) |=> !at_speed_raw_q)
    else $error("Arrival flag set while ramping or disabled");

  a_arrive_above_off: assert property (
    (i_out_freq > i_target_freq + `DSF_ARRIVE_ABOVE) && !i_target_freq[VW-1]
      |=> !at_speed_raw_q)
    else $error("Arrival flag set above window");

  a_thr_accel_on: assert property (
    s_accel_cross |=> thr_raw_q)
    else $error("Threshold flag missed accel crossing");

  a_thr_decel_off: assert property (
    s_decel_cross |=> !thr_raw_q)
    else $error("Threshold flag missed decel crossing");

  a_thr_hold_cruise: assert property (
    i_output_enabled && !ramping && thr_raw_q |=> thr_raw_q)
    else $error("Threshold flag dropped without decel crossing");

  a_ovl_compare: assert property (
    i_out_current > ovl_level_q |=> ovl_q ##0 o_flags.overcurrent_warning)
    else $error("Overload warning missing above level");

  a_ovl_below: assert property (
    i_out_current < ovl_level_q |=> !ovl_q)
    else $error("Overload warning present below level");

  a_ovl_default: assert property (
    $rose(i_nrst) ##0 !i_ovl_level_wr |=> ovl_level_q == `DSF_OVL_DEFAULT)
    else $error("Overload level not at reset default");

  a_dev_default: assert property (
    $rose(i_nrst) ##0 !i_dev_level_wr |=> dev_level_q == `DSF_DEV_DEFAULT)
    else $error("Deviation level not at reset default");

  a_pid_abs: assert property (
    (i_pid_feedback > i_pid_setpoint) &&
      (i_pid_feedback - i_pid_setpoint > dev_level_q) |=> pid_q)
    else $error("PID flag missing for negative error");

  a_pid_below: assert property (
    pid_err < dev_level_q |=> !pid_q)
    else $error("PID flag present below level");

  a_oc_active_low: assert property (
    ##1 o_oc_oe[0] |-> !o_oc_n[0])
    else $error("Terminal conducting but not low");

  a_oc_overload: assert property (
    i_oc_func[0] == DSF_FN_OVERLOAD |=> o_oc_oe[0] == $past(ovl_q))
    else $error("Terminal not showing overload warning");

  a_relay_unpowered: assert property (
    !i_power_ok |=> o_relay_contact_b_closed && !o_relay_contact_a_closed)
    else $error("Relay not in tripped position when unpowered");

  a_relay_invert: assert property (
    i_power_ok && i_relay_func == DSF_FN_ALARM && flags.fault_alarm
      |=> o_relay_contact_a_closed == $past(i_relay_invert))
    else $error("Relay polarity not applied on alarm");

  a_alarm_no_trip: assert property (
    !trip_q [*2] ##1 1'b1 |-> !$rose(alarm_dly))
    else $error("Alarm rose without trip");

endmodule // dsf_top
`default_nettype wire

// ===== rtl/dsf_consts.svh
// Purpose: Constants of the drive status flag block
// Assumes: Frequency in 0.1 Hz units, current and PID values in 0.1 % units
// Notes: Timing figures kept in their own unit; cycle counts derived in the code
`ifndef DSF_CONSTS_SVH
`define DSF_CONSTS_SVH

// Arrival window below and above target, 0.1 Hz units (0.5 Hz, 1.5 Hz)
`define DSF_ARRIVE_BELOW 16'h0005
`define DSF_ARRIVE_ABOVE 16'h000F

// Reset levels, 0.1 % units (100 %, 3 %)
`define DSF_OVL_DEFAULT 16'h03E8
`define DSF_DEV_DEFAULT 16'h001E

// System clock rate in Hz and milliseconds per second
`define DSF_MCLK_HZ 50000000
`define DSF_MS_PER_S 1000

// Output delays in milliseconds
`define DSF_FLAG_DELAY_MS 60
`define DSF_ALARM_DELAY_MS 300

`endif

// ===== rtl/dsf_pkg.sv
// Purpose: Types shared by the drive status flag block
// Assumes: Constants come from dsf_consts.svh
// Notes: Function codes follow the terminal assignment codes
`default_nettype none
package dsf_pkg;

  // Terminal function codes
  typedef enum logic [2:0] {
    DSF_FN_NONE = 3'h0,
    DSF_FN_AT_SPEED = 3'h1,
    DSF_FN_THRESHOLD = 3'h2,
    DSF_FN_OVERLOAD = 3'h3,
    DSF_FN_PID_ERROR = 3'h4,
    DSF_FN_ALARM = 3'h5
  } dsf_func_t;

  // Delay line states, one-hot
  typedef enum logic [1:0] {
    DSF_ST_STABLE = 2'h1,
    DSF_ST_TIMING = 2'h2
  } dsf_state_t;

  // Status flags; arrival, threshold and alarm after their delays
  typedef struct packed {
    logic at_speed_flag;
    logic threshold_speed_flag;
    logic overcurrent_warning;
    logic pid_error_flag;
    logic fault_alarm;
  } dsf_flags_t;

endpackage
`default_nettype wire

// ===== rtl/dsf_delay.sv
// Purpose: Delays each change of a flag by a whole number of milliseconds
// Assumes: i_ms_tick is a one-cycle pulse once per millisecond
// Notes: A change withdrawn before the delay ends never reaches the output
`timescale 1ns/10ps
`default_nettype none
module dsf_delay import dsf_pkg::*; #(
  parameter int DELAY_MS = 60
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ms_tick,
  input wire logic i_in,
  output logic o_out
);

  localparam int CW = $clog2(DELAY_MS + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_MS);

  dsf_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic out_d;
  wire logic differs = i_in != o_out;
  wire logic expired = i_ms_tick && (cnt_q == LAST);

  // Restart on a new change, fire after DELAY_MS full ticks
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    out_d = o_out;
    case (state_q)
      DSF_ST_STABLE: begin
        if (differs) begin
          state_d = DSF_ST_TIMING;
          cnt_d = '0;
        end
      end
      DSF_ST_TIMING: begin
        if (!differs) begin
          state_d = DSF_ST_STABLE;
        end else if (expired) begin
          out_d = i_in;
          state_d = DSF_ST_STABLE;
        end else if (i_ms_tick) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: state_d = DSF_ST_STABLE;
    endcase
  end

  // State registers
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state_q <= DSF_ST_STABLE;
      cnt_q <= '0;
      o_out <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      o_out <= out_d;
    end
  end

  a_delay_no_early: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $changed(o_out) |-> $past(state_q) == DSF_ST_TIMING && $past(expired))
    else $error("Delayed flag changed before its delay expired");

endmodule // dsf_delay
`default_nettype wire

// ===== dv/dsf_load_model.sv
// Purpose: Far side of the status outputs: pulled-up controller inputs and relay sense
// Assumes: Terminals are open collector with a pull-up at the controller
// Notes: A released terminal reads high, never the last driven level
`timescale 1ns/10ps
`default_nettype none
module dsf_load_model (
  input wire logic [1:0] i_oc_oe,
  input wire logic i_contact_a_closed,
  input wire logic i_contact_b_closed,
  output logic [1:0] o_term_level,
  output logic o_relay_sense
);
  // pull-up wiring
  // Transistor on pulls the line low, otherwise the pull-up wins
  assign o_term_level[0] = i_oc_oe[0] ? 1'b0 : 1'b1;
  assign o_term_level[1] = i_oc_oe[1] ? 1'b0 : 1'b1;
  // contact sensing
  // Controller sees the a-side contact; a contact fault reads inactive
  assign o_relay_sense = i_contact_a_closed & ~i_contact_b_closed;
endmodule // dsf_load_model
`default_nettype wire

// ===== dv/tb_drive_status_output_flags.sv
// Purpose: Self-checking bench of the status flag block
// Assumes: Shortened timebase: 10 cycles a ms, delays 3 ms and 5 ms
// Notes: Inputs change at the falling edge; flag delays checked in a window
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_drive_status_output_flags;
  import dsf_pkg::*;
  localparam int CPM = 10;
  localparam int FD = 3;
  localparam int AD = 5;
  int failures = 0;
  int checks_done = 0;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] freq = 16'h0000, tgt = 16'h01F4, acc_on = 16'h012C, dec_off = 16'h00C8;
  logic [15:0] cur = 16'h0000, ovl = 16'h0000, sp = 16'h0064, fb = 16'h0064, dev = 16'h0000;
  logic en = 1'b1, accel = 1'b0, decel = 1'b0, ovl_wr = 1'b0, dev_wr = 1'b0;
  logic trip = 1'b0, pwr = 1'b1, inv = 1'b0;
  dsf_func_t oc_func [2];
  dsf_func_t rly_func = DSF_FN_ALARM;
  logic [1:0] oc_oe, oc_n, lvl;
  logic ca, cb, sense;
  dsf_flags_t flags;
  // Clock of 20 ns period
  always #10 clk = ~clk;
  dsf_top #(.CYC_PER_MS(CPM), .FLAG_DELAY_MS(FD), .ALARM_DELAY_MS(AD), .VW(16)) i_dut (
    .i_mclk(clk), .i_nrst(nrst), .i_out_freq(freq), .i_target_freq(tgt),
    .i_accel_on_freq(acc_on), .i_decel_off_freq(dec_off), .i_output_enabled(en),
    .i_accelerating(accel), .i_decelerating(decel), .i_out_current(cur),
    .i_ovl_level(ovl), .i_ovl_level_wr(ovl_wr), .i_pid_setpoint(sp), .i_pid_feedback(fb),
    .i_dev_level(dev), .i_dev_level_wr(dev_wr), .i_tripped(trip), .i_power_ok(pwr),
    .i_relay_invert(inv), .i_oc_func(oc_func), .i_relay_func(rly_func), .o_oc_oe(oc_oe),
    .o_oc_n(oc_n), .o_relay_contact_a_closed(ca), .o_relay_contact_b_closed(cb),
    .o_flags(flags));
  dsf_load_model i_load (.i_oc_oe(oc_oe), .i_contact_a_closed(ca),
    .i_contact_b_closed(cb), .o_term_level(lvl), .o_relay_sense(sense));
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Terminal pin and the level the controller sees
  task automatic term(input int t, input logic act);
    `CHK("terminal pin", ~act, oc_n[t])
    `CHK("terminal line", ~act, lvl[t])
  endtask
  // Waits for a flag bit inside the delay window
  task automatic wait_flag(input int b, input logic v, input int dly, input string nm);
    int n;
    n = 0;
    while (flags[b] !== v && n < (dly + 1) * CPM + 4) begin
      @(negedge clk);
      n++;
    end
    `CHK(nm, 1'b1, (n >= dly * CPM - 2 && n < (dly + 1) * CPM + 4))
    if (n >= (dly + 1) * CPM + 4) wrap_up();
  endtask
  initial begin
    oc_func[0] = DSF_FN_OVERLOAD;
    oc_func[1] = DSF_FN_PID_ERROR;
    step(3);
    `CHK("reset pins", 4'h3, {oc_oe, oc_n})
    `CHK("reset relay", 2'h1, {ca, cb})
    `CHK("reset flags", 5'h00, flags)
    step(1);
    nrst = 1'b1;
    step(2);
    `CHK("relay healthy", 1'b1, sense)
    $display("test reset finished");
    cur = 16'h03E8;
    step(2);
    `CHK("overload at level", 1'b0, flags.overcurrent_warning)
    cur = 16'h03E9;
    step(1);
    `CHK("overload on", 1'b1, flags.overcurrent_warning)
    step(1);
    term(0, 1'b1);
    cur = 16'h03E7;
    step(2);
    term(0, 1'b0);
    ovl = 16'h01F4;
    ovl_wr = 1'b1;
    step(1);
    ovl_wr = 1'b0;
    cur = 16'h01F5;
    step(2);
    term(0, 1'b1);
    cur = 16'h0000;
    $display("test overload finished");
    fb = 16'h0082;
    step(2);
    `CHK("pid at level", 1'b0, flags.pid_error_flag)
    fb = 16'h0045;
    step(2);
    term(1, 1'b1);
    fb = 16'h0047;
    step(2);
    term(1, 1'b0);
    dev = 16'h000A;
    dev_wr = 1'b1;
    step(1);
    dev_wr = 1'b0;
    fb = 16'h006F;
    step(2);
    term(1, 1'b1);
    fb = 16'h0064;
    $display("test pid finished");
    oc_func[0] = DSF_FN_AT_SPEED;
    oc_func[1] = DSF_FN_THRESHOLD;
    freq = 16'h01EF;
    wait_flag(4, 1'b1, FD, "arrive low edge");
    step(1);
    term(0, 1'b1);
    freq = 16'h01EE;
    wait_flag(4, 1'b0, FD, "leave low edge");
    freq = 16'h0203;
    wait_flag(4, 1'b1, FD, "arrive high edge");
    freq = 16'h0204;
    wait_flag(4, 1'b0, FD, "leave high edge");
    freq = 16'h01F4;
    accel = 1'b1;
    step((FD + 2) * CPM);
    `CHK("arrival ramping", 1'b0, flags.at_speed_flag)
    accel = 1'b0;
    wait_flag(4, 1'b1, FD, "arrival steady");
    en = 1'b0;
    wait_flag(4, 1'b0, FD, "arrival disabled");
    en = 1'b1;
    $display("test arrival finished");
    freq = 16'h012B;
    accel = 1'b1;
    step((FD + 2) * CPM);
    `CHK("threshold below", 1'b0, flags.threshold_speed_flag)
    freq = 16'h012C;
    wait_flag(3, 1'b1, FD, "threshold on");
    step(1);
    term(1, 1'b1);
    accel = 1'b0;
    decel = 1'b1;
    freq = 16'h00C8;
    step((FD + 2) * CPM);
    `CHK("threshold decel", 1'b1, flags.threshold_speed_flag)
    freq = 16'h00C7;
    wait_flag(3, 1'b0, FD, "threshold off");
    dec_off = 16'h012C;
    decel = 1'b0;
    accel = 1'b1;
    freq = 16'h012C;
    wait_flag(3, 1'b1, FD, "equal levels on");
    accel = 1'b0;
    decel = 1'b1;
    freq = 16'h012B;
    wait_flag(3, 1'b0, FD, "equal levels off");
    decel = 1'b0;
    $display("test threshold finished");
    oc_func[0] = DSF_FN_ALARM;
    trip = 1'b1;
    wait_flag(0, 1'b1, AD, "alarm on");
    step(1);
    `CHK("relay tripped", 2'h1, {ca, cb})
    term(0, 1'b1);
    inv = 1'b1;
    step(2);
    `CHK("relay inverted", 2'h2, {ca, cb})
    pwr = 1'b0;
    step(2);
    `CHK("relay unpowered", 2'h1, {ca, cb})
    pwr = 1'b1;
    inv = 1'b0;
    trip = 1'b0;
    wait_flag(0, 1'b0, AD, "alarm off");
    step(1);
    `CHK("relay cleared", 1'b1, sense)
    $display("test alarm finished");
    cur = 16'h07D0;
    foreach (oc_func[i]) oc_func[i] = DSF_FN_NONE;
    rly_func = DSF_FN_OVERLOAD;
    step(2);
    `CHK("relay overload", 1'b0, ca)
    for (int c = 6; c < 9; c++) begin
      oc_func[0] = dsf_func_t'(3'(c));
      oc_func[1] = dsf_func_t'(3'(c));
      rly_func = dsf_func_t'(3'(c));
      step(2);
      term(0, 1'b0);
      term(1, 1'b0);
      `CHK("relay no function", 1'b1, ca)
    end
    cur = 16'h0320;
    step(1);
    nrst = 1'b0;
    step(2);
    `CHK("second reset", 5'h00, flags)
    nrst = 1'b1;
    step(2);
    `CHK("level after reset", 1'b0, flags.overcurrent_warning)
    $display("test codes finished");
    wrap_up();
  end
endmodule // tb_drive_status_output_flags
`default_nettype wire
